// File: rtl/ilas_pkg.sv
// Purpose: shared constants for the inductance limit and status register block
// Assumes: 7-bit register addresses, 8-bit register data
// Notes: timing figures are in ns; cycle counts derive from the 20 MHz ref_clk

package ilas_pkg;

  // ----------------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------------
  localparam logic [6:0] ILAS_ADDR_INT_FUNC = 7'h0A;
  localparam logic [6:0] ILAS_ADDR_UP_LOW = 7'h16;
  localparam logic [6:0] ILAS_ADDR_UP_HIGH = 7'h17;
  localparam logic [6:0] ILAS_ADDR_LO_LOW = 7'h18;
  localparam logic [6:0] ILAS_ADDR_LO_HIGH = 7'h19;
  localparam logic [6:0] ILAS_ADDR_STATUS = 7'h20;

  // ----------------------------------------------------------------------
  // reset values, latch clear write value and unmapped read value
  // ----------------------------------------------------------------------
  localparam logic [7:0] ILAS_LIMIT_BYTE_RESET = 8'h00;
  localparam logic [7:0] ILAS_STATUS_RESET = 8'h00;
  localparam logic [7:0] ILAS_CLEAR_VALUE = 8'h00;
  localparam logic [7:0] ILAS_UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------------
  localparam int ILAS_ST_OSC_LOST = 7;
  localparam int ILAS_ST_READY_LOW = 6;
  localparam int ILAS_ST_R_OVER = 5;
  localparam int ILAS_ST_R_WINDOW = 4;
  localparam int ILAS_ST_L_OVER = 3;
  localparam int ILAS_ST_L_WINDOW = 2;
  localparam int ILAS_ST_RESERVED = 1;
  localparam int ILAS_ST_BUSY = 0;

  // ----------------------------------------------------------------------
  // interrupt pin function codes that enable the latched flags
  // ----------------------------------------------------------------------
  localparam logic [5:0] ILAS_FUNC_R_LATCH = 6'h01;
  localparam logic [5:0] ILAS_FUNC_L_LATCH = 6'h08;

  // ----------------------------------------------------------------------
  // serial port framing
  // ----------------------------------------------------------------------
  localparam logic [4:0] ILAS_CMD_BITS = 5'h08;
  localparam logic [4:0] ILAS_FRAME_BITS = 5'h10;
  localparam int ILAS_CMD_READ_BIT = 7;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int ILAS_CLK_HZ = 20000000;
  localparam int ILAS_SETTLE_NS = 1000;
  localparam int ILAS_SETTLE_CYCLES_INT =
    (ILAS_SETTLE_NS * (ILAS_CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [7:0] ILAS_SETTLE_CYCLES = 8'(ILAS_SETTLE_CYCLES_INT);

endpackage : ilas_pkg

// File: rtl/ilas_spi_port.sv
// Purpose: serial register port, mode 0, command byte then one data byte
// Assumes: serial clock at most ref_clk / 8 so synchronised edges are seen
// Notes: command bit 7 high means read, bits 6:0 are the address

`timescale 1ns/100ps

module ilas_spi_port
  import ilas_pkg::*;
(
  input wire logic ref_clk, // device clock
  input wire logic reset, // synchronous reset, active high
  input wire logic sclk, // serial clock pin
  input wire logic cs_low, // chip select pin, active low
  input wire logic mosi, // serial data in pin
  input wire logic [7:0] rd_data, // read data for reg_addr
  output logic [6:0] reg_addr, // address of current frame
  output logic wr_pulse, // one-cycle write strobe
  output logic [7:0] wr_data, // write data
  output logic rd_pulse, // one-cycle read strobe
  output logic miso, // serial data out
  output logic miso_oe // drive enable of serial data out
);

  typedef struct packed {
    logic [1:0] sclk_sync;
    logic sclk_prev;
    logic [1:0] cs_sync;
    logic [1:0] mosi_sync;
    logic [4:0] bit_cnt;
    logic [7:0] rx;
    logic is_read;
    logic [6:0] addr;
    logic load;
    logic [7:0] tx;
    logic miso;
    logic miso_oe;
    logic wr;
    logic [7:0] wdata;
  } ilas_spi_s;

  ilas_spi_s st_q;
  ilas_spi_s st_d;

  logic rise;
  logic fall;
  logic [7:0] rx_next;

  always_comb
  begin
    st_d = st_q;
    st_d.sclk_sync = {st_q.sclk_sync[0], sclk};
    st_d.cs_sync = {st_q.cs_sync[0], cs_low};
    st_d.mosi_sync = {st_q.mosi_sync[0], mosi};
    st_d.sclk_prev = st_q.sclk_sync[1];
    rise = st_q.sclk_sync[1] & ~st_q.sclk_prev;
    fall = ~st_q.sclk_sync[1] & st_q.sclk_prev;
    rx_next = {st_q.rx[6:0], st_q.mosi_sync[1]};
    st_d.wr = 1'b0;
    st_d.load = 1'b0;
    st_d.miso_oe = ~st_q.cs_sync[1];
    if (st_q.load)
    begin
      st_d.tx = rd_data;
    end
    if (st_q.cs_sync[1])
    begin
      // deselected: frame aborts, partial writes are dropped
      st_d.bit_cnt = 5'h00;
      st_d.miso = 1'b0;
    end
    else if (rise && st_q.bit_cnt != ILAS_FRAME_BITS)
    begin
      st_d.rx = rx_next;
      st_d.bit_cnt = st_q.bit_cnt + 5'h01;
      if (st_q.bit_cnt == ILAS_CMD_BITS - 5'h01)
      begin
        st_d.is_read = rx_next[ILAS_CMD_READ_BIT];
        st_d.addr = rx_next[6:0];
        st_d.load = 1'b1;
      end
      else if (st_q.bit_cnt == ILAS_FRAME_BITS - 5'h01)
      begin
        st_d.wr = ~st_q.is_read;
        st_d.wdata = rx_next;
      end
    end
    else if (fall && st_q.bit_cnt >= ILAS_CMD_BITS && st_q.is_read)
    begin
      st_d.miso = st_q.tx[7];
      st_d.tx = {st_q.tx[6:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st_q <= '0;
      st_q.sclk_sync <= 2'h0;
      st_q.cs_sync <= 2'h3;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign reg_addr = st_q.addr;
  assign wr_pulse = st_q.wr;
  assign wr_data = st_q.wdata;
  assign rd_pulse = st_q.load & st_q.is_read;
  assign miso = st_q.miso;
  assign miso_oe = st_q.miso_oe;

endmodule : ilas_spi_port

// File: rtl/ilas_limits_status.sv
// Purpose: inductance limit registers, limit comparators and status register
// Assumes: result inputs come from the conversion core on ref_clk
// Notes: the serial port front end lives in ilas_spi_port
//
// What this block does
// - upper inductance limit is byte 0x17 high, byte 0x16 low; both reset zero.
// - lower inductance limit is byte 0x19 times 256 plus byte 0x18; reset zero.
// - inductance result below lower limit sets the inductance window state.
// - low byte of lower limit is buffered until its high byte is written.
// - limit writes are accepted during conversions and apply immediately.
// - status bit 7 is 1 while sensor oscillation is not detected.
// - status bit 6 is 0 when a new result exists, else 1.
// - status bit 5 latches low on resistance over-limit; 0x00 to 0x0A clears.
// - status bit 3 latches low on inductance over-limit; 0x00 to 0x0A clears.
// - status bit 4 is the resistance hysteresis comparator state.
// - status bit 2 is the inductance hysteresis comparator state.
// - status bit 0 is 1 while reset completes; writes refused meanwhile.
// - inductance result above upper limit sets the inductance over-limit latch.
// - low byte of upper limit is buffered until its high byte is written.

`timescale 1ns/100ps

module ilas_limits_status
  import ilas_pkg::*;
(
  input wire logic ref_clk, // device clock, 20 MHz
  input wire logic reset, // synchronous reset, active high
  input wire logic sclk, // serial clock pin
  input wire logic cs_low, // serial chip select, active low
  input wire logic mosi, // serial data in
  output logic miso, // serial data out
  output logic miso_oe, // serial data out drive enable
  input wire logic osc_lost, // sensor oscillation missing, asynchronous
  input wire logic l_valid, // one-cycle pulse, new inductance result
  input wire logic [15:0] l_result, // inductance result
  input wire logic r_valid, // one-cycle pulse, new resistance result
  input wire logic [15:0] r_result, // resistance result
  input wire logic [15:0] resistance_upper_limit, // from resistance limit registers
  input wire logic [15:0] resistance_lower_limit, // from resistance limit registers
  input wire logic [5:0] interrupt_pin_function, // from register 0x0A
  output logic [15:0] inductance_upper_limit, // active upper limit
  output logic [15:0] inductance_lower_limit, // active lower limit
  output logic [7:0] status_byte, // status register image
  output logic settle_busy // reset still completing
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] up_low_buf;
    logic [15:0] up_lim;
    logic [7:0] lo_low_buf;
    logic [15:0] lo_lim;
    logic l_over;
    logic l_window;
    logic r_over;
    logic r_window;
    logic ready_low;
    logic l_seen;
    logic r_seen;
    logic [1:0] osc_sync;
    logic [7:0] settle_cnt;
    logic busy;
    logic [7:0] status;
  } ilas_state_s;

  ilas_state_s st_q;
  ilas_state_s st_d;

  logic [6:0] reg_addr;
  logic wr_pulse;
  logic [7:0] wr_data;
  logic rd_pulse;
  logic [7:0] rd_data;
  logic wr_ok;
  logic clear_latch;
  logic l_above_up;
  logic r_above_up;
  logic both_seen;
  logic r_report;
  logic l_report;
  logic l_below_lo;
  logic r_below_lo;
  logic status_read;
  logic [7:0] status_img;

  // ----------------------------------------------------------------------
  // serial front end
  // ----------------------------------------------------------------------
  ilas_spi_port u_port (
    .ref_clk(ref_clk),
    .reset(reset),
    .sclk(sclk),
    .cs_low(cs_low),
    .mosi(mosi),
    .rd_data(rd_data),
    .reg_addr(reg_addr),
    .wr_pulse(wr_pulse),
    .wr_data(wr_data),
    .rd_pulse(rd_pulse),
    .miso(miso),
    .miso_oe(miso_oe)
  );

  // ----------------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    if (reg_addr == ILAS_ADDR_UP_LOW)
    begin
      // low bytes read the active limit, not the buffered byte
      rd_data = st_q.up_lim[7:0];
    end
    else if (reg_addr == ILAS_ADDR_UP_HIGH)
    begin
      rd_data = st_q.up_lim[15:8];
    end
    else if (reg_addr == ILAS_ADDR_LO_LOW)
    begin
      rd_data = st_q.lo_lim[7:0];
    end
    else if (reg_addr == ILAS_ADDR_LO_HIGH)
    begin
      rd_data = st_q.lo_lim[15:8];
    end
    else if (reg_addr == ILAS_ADDR_STATUS)
    begin
      rd_data = st_q.status;
    end
    else
    begin
      rd_data = ILAS_UNMAPPED_READ;
    end
  end

  // ----------------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------------
  // write data, including to the status address, is never stored in the status image
  // limitation: a frame that ends while busy loses its write without notice
  always_comb
  begin
    wr_ok = wr_pulse & ~st_q.busy;
    clear_latch = wr_ok && reg_addr == ILAS_ADDR_INT_FUNC && wr_data == ILAS_CLEAR_VALUE;
  end

  // ----------------------------------------------------------------------
  // result events
  // ----------------------------------------------------------------------
  // strict compares: a result equal to a limit leaves every flag alone
  always_comb
  begin
    l_above_up = l_valid && (l_result > st_q.up_lim);
    l_below_lo = l_valid && (l_result < st_q.lo_lim);
    r_above_up = r_valid && (r_result > resistance_upper_limit);
    r_below_lo = r_valid && (r_result < resistance_lower_limit);
    both_seen = (st_q.l_seen | l_valid) & (st_q.r_seen | r_valid);
    status_read = rd_pulse && reg_addr == ILAS_ADDR_STATUS;
  end

  // ----------------------------------------------------------------------
  // status image
  // ----------------------------------------------------------------------
  // latched flags only show under their pin function, else read not-exceeded
  // registered one cycle behind the flags so a read sees one consistent byte
  always_comb
  begin
    r_report = (interrupt_pin_function == ILAS_FUNC_R_LATCH) ? ~st_q.r_over : 1'b1;
    l_report = (interrupt_pin_function == ILAS_FUNC_L_LATCH) ? ~st_q.l_over : 1'b1;
    status_img = ILAS_STATUS_RESET;
    status_img[ILAS_ST_OSC_LOST] = st_q.osc_sync[1];
    status_img[ILAS_ST_READY_LOW] = st_q.ready_low;
    status_img[ILAS_ST_R_OVER] = r_report;
    status_img[ILAS_ST_R_WINDOW] = st_q.r_window;
    status_img[ILAS_ST_L_OVER] = l_report;
    status_img[ILAS_ST_L_WINDOW] = st_q.l_window;
    status_img[ILAS_ST_RESERVED] = 1'b0;
    status_img[ILAS_ST_BUSY] = st_q.busy;
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;

    // only the second stage is read by logic
    st_d.osc_sync = {st_q.osc_sync[0], osc_lost};

    // settle counter after reset release
    // a counter, so the window follows the settle time constant
    if (st_q.settle_cnt != 8'h00)
    begin
      st_d.settle_cnt = st_q.settle_cnt - 8'h01;
    end
    st_d.busy = (st_q.settle_cnt != 8'h00);

    // no mode gating: limit writes land while conversions run
    if (wr_ok)
    begin
      if (reg_addr == ILAS_ADDR_UP_LOW)
      begin
        st_d.up_low_buf = wr_data;
      end
      else if (reg_addr == ILAS_ADDR_UP_HIGH)
      begin
        st_d.up_lim = {wr_data, st_q.up_low_buf};
      end
      else if (reg_addr == ILAS_ADDR_LO_LOW)
      begin
        st_d.lo_low_buf = wr_data;
      end
      else if (reg_addr == ILAS_ADDR_LO_HIGH)
      begin
        st_d.lo_lim = {wr_data, st_q.lo_low_buf};
      end
    end

    // a new over-limit event beats a clear in the same cycle
    st_d.l_over = (st_q.l_over & ~clear_latch) | l_above_up;
    st_d.r_over = (st_q.r_over & ~clear_latch) | r_above_up;

    // hysteresis: set below lower, release above upper, hold between
    if (l_below_lo)
    begin
      st_d.l_window = 1'b1;
    end
    else if (l_above_up)
    begin
      st_d.l_window = 1'b0;
    end
    if (r_below_lo)
    begin
      st_d.r_window = 1'b1;
    end
    else if (r_above_up)
    begin
      st_d.r_window = 1'b0;
    end

    // ready once both halves of a result pair have arrived
    st_d.l_seen = st_q.l_seen | l_valid;
    st_d.r_seen = st_q.r_seen | r_valid;
    if (both_seen)
    begin
      st_d.l_seen = 1'b0;
      st_d.r_seen = 1'b0;
      st_d.ready_low = 1'b0;
    end
    else if (status_read)
    begin
      st_d.ready_low = 1'b1;
    end

    st_d.status = status_img;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      // over latches start clear, so bits 5 and 3 read 1 once running
      st_q.up_low_buf <= ILAS_LIMIT_BYTE_RESET;
      st_q.up_lim <= {ILAS_LIMIT_BYTE_RESET, ILAS_LIMIT_BYTE_RESET};
      st_q.lo_low_buf <= ILAS_LIMIT_BYTE_RESET;
      st_q.lo_lim <= {ILAS_LIMIT_BYTE_RESET, ILAS_LIMIT_BYTE_RESET};
      st_q.ready_low <= 1'b1;
      st_q.settle_cnt <= ILAS_SETTLE_CYCLES;
      st_q.busy <= 1'b1;
      st_q.status <= ILAS_STATUS_RESET;
      st_q.l_over <= 1'h0;
      st_q.l_window <= 1'h0;
      st_q.r_over <= 1'h0;
      st_q.r_window <= 1'h0;
      st_q.l_seen <= 1'h0;
      st_q.r_seen <= 1'h0;
      st_q.osc_sync <= 2'h0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // limits leave as registers so outside comparators never see a glitch
  assign inductance_upper_limit = st_q.up_lim;
  assign inductance_lower_limit = st_q.lo_lim;
  assign status_byte = st_q.status;
  assign settle_busy = st_q.busy;

endmodule : ilas_limits_status

// File: testbench/ilas_limits_status_chk.sv
// Purpose: port assertions for ilas_limits_status
// Assumes: one ref_clk domain, synchronous reset
// Notes: bound to every instance of the block
`timescale 1ns/100ps

module ilas_limits_status_chk
  import ilas_pkg::*;
(
  input wire logic ref_clk, // device clock
  input wire logic reset, // sync reset
  input wire logic osc_lost, // oscillation missing
  input wire logic l_valid, // inductance strobe
  input wire logic [15:0] l_result, // inductance result
  input wire logic r_valid, // resistance strobe
  input wire logic [15:0] r_result, // resistance result
  input wire logic [15:0] resistance_upper_limit, // resistance upper
  input wire logic [5:0] interrupt_pin_function, // flag select
  input wire logic [15:0] inductance_upper_limit, // active upper
  input wire logic [15:0] inductance_lower_limit, // active lower
  input wire logic [7:0] status_byte, // status image
  input wire logic settle_busy // settling
);
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  AST_RSV: assert property (status_byte[1] == 1'b0)
    else $error("reserved status bit set");
  AST_BUSY_BIT: assert property (!$past(reset) |-> status_byte[0] == $past(settle_busy))
    else $error("status bit 0 not following settle");
  AST_SETTLE: assert property ($fell(reset) |-> settle_busy [*8] ##[10:16] !settle_busy)
    else $error("settle length wrong");
  AST_HOLD: assert property (settle_busy |=> $stable(inductance_upper_limit)
    && $stable(inductance_lower_limit)) else $error("limit written while settling");
  AST_L_OVER: assert property (l_valid && l_result > inductance_upper_limit
    && interrupt_pin_function == ILAS_FUNC_L_LATCH |-> ##2 !status_byte[3])
    else $error("inductance over latch missing");
  AST_L_WIN_SET: assert property (l_valid && l_result < inductance_lower_limit
    && l_result <= inductance_upper_limit |-> ##2 status_byte[2])
    else $error("inductance window not set");
  AST_L_WIN_CLR: assert property (l_valid && l_result > inductance_upper_limit
    && l_result >= inductance_lower_limit |-> ##2 !status_byte[2])
    else $error("inductance window not cleared");
  AST_R_OVER: assert property (r_valid && r_result > resistance_upper_limit
    && interrupt_pin_function == ILAS_FUNC_R_LATCH |-> ##2 !status_byte[5])
    else $error("resistance over latch missing");
  AST_OSC: assert property (osc_lost [*6] |-> status_byte[7])
    else $error("oscillation loss not shown");
endmodule : ilas_limits_status_chk

bind ilas_limits_status ilas_limits_status_chk chk_u (.ref_clk, .reset, .osc_lost, .l_valid,
  .l_result, .r_valid, .r_result, .resistance_upper_limit, .interrupt_pin_function,
  .inductance_upper_limit, .inductance_lower_limit, .status_byte, .settle_busy);

// File: testbench/ilas_host_model.sv
// Purpose: host controller model driving serial register frames
// Assumes: caller enters xfer just after a falling ref_clk edge
// Notes: each serial phase lasts 6 ref_clk, above the 4 the port needs
`timescale 1ns/100ps

module ilas_host_model
  import ilas_pkg::*;
(
  input wire logic ref_clk, // device clock
  input wire logic miso, // serial data from device
  output logic sclk, // serial clock, idle low
  output logic cs_low, // chip select, active low
  output logic mosi // serial data to device
);
  initial
  begin
    sclk = 1'b0;
    cs_low = 1'b1;
    mosi = 1'b0;
  end

  // ------------------------------------------------------------
  // one frame: command byte then data byte, msb first
  // ------------------------------------------------------------
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    cs_low = 1'b0;
    repeat (6) @(negedge ref_clk);
    for (int i = 15; i >= 0; i--)
    begin
      mosi = sh[i];
      repeat (6) @(negedge ref_clk);
      sclk = 1'b1;
      if (i < 8)
        rd[i] = miso;
      repeat (6) @(negedge ref_clk);
      sclk = 1'b0;
    end
    repeat (6) @(negedge ref_clk);
    cs_low = 1'b1;
    // deselected line must not keep the last bit
    mosi = ~mosi;
    repeat (8) @(negedge ref_clk);
  endtask : xfer
endmodule : ilas_host_model

// File: testbench/ilas_limits_status_test.sv
// Purpose: self-checking bench for ilas_limits_status
// Assumes: window flags start at 0 after reset
// Notes: inputs change at the falling ref_clk edge
`timescale 1ns/100ps

module ilas_limits_status_test
  import ilas_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic osc_lost = 1'b0;
  logic l_valid = 1'b0;
  logic r_valid = 1'b0;
  logic [15:0] l_result = 16'h0000;
  logic [15:0] r_result = 16'h0000;
  logic [5:0] func = 6'h00;
  logic [15:0] r_up = 16'h2000;
  logic [15:0] r_lo = 16'h1000;
  logic sclk, cs_low, mosi, miso, miso_oe, settle_busy;
  logic [15:0] up_lim, lo_lim;
  logic [7:0] status_byte, rd_v;
  int error_cnt = 0;
  int n_compared = 0;

  always #25 ref_clk = ~ref_clk;

  ilas_host_model host_u (.ref_clk, .miso, .sclk, .cs_low, .mosi);
  ilas_limits_status dut_u (.ref_clk, .reset, .sclk, .cs_low, .mosi, .miso, .miso_oe,
    .osc_lost, .l_valid, .l_result, .r_valid, .r_result,
    .resistance_upper_limit(r_up), .resistance_lower_limit(r_lo),
    .interrupt_pin_function(func), .inductance_upper_limit(up_lim),
    .inductance_lower_limit(lo_lim), .status_byte, .settle_busy);

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test;
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer({1'b0, a}, d, rd_v);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    host_u.xfer({1'b1, a}, 8'h00, rd_v);
    check({8'h00, rd_v}, {8'h00, e});
  endtask : rd

  task automatic st(input logic [7:0] e);
    check({8'h00, status_byte}, {8'h00, e});
  endtask : st

  // one result pulse, then time for flags and status image
  task automatic res(input logic [15:0] l, input logic [15:0] r, input logic lv, input logic rv);
    l_result = l;
    r_result = r;
    l_valid = lv;
    r_valid = rv;
    @(negedge ref_clk);
    l_valid = 1'b0;
    r_valid = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask : res

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    check({15'h0000, settle_busy}, 16'h0001);
    check({15'h0000, miso_oe}, 16'h0000);
    repeat (2) @(negedge ref_clk);
    check({15'h0000, status_byte[0]}, 16'h0001);
    fork
      rd(ILAS_ADDR_STATUS, 8'h68);
      begin
        repeat (20) @(negedge ref_clk);
        check({15'h0000, miso_oe}, 16'h0001);
      end
    join
    for (int i = 0; i < 4; i++)
      rd(7'(ILAS_ADDR_UP_LOW + i), 8'h00);
    wr(ILAS_ADDR_STATUS, 8'hFF);
    rd(ILAS_ADDR_STATUS, 8'h68);
    rd(7'h7F, ILAS_UNMAPPED_READ);
    wr(ILAS_ADDR_UP_LOW, 8'h34);
    check(up_lim, 16'h0000);
    rd(ILAS_ADDR_UP_LOW, 8'h00);
    wr(ILAS_ADDR_UP_HIGH, 8'h12);
    check(up_lim, 16'h1234);
    rd(ILAS_ADDR_UP_LOW, 8'h34);
    wr(ILAS_ADDR_LO_LOW, 8'h78);
    check(lo_lim, 16'h0000);
    wr(ILAS_ADDR_LO_HIGH, 8'h05);
    check(lo_lim, 16'h0578);
    func = ILAS_FUNC_L_LATCH;
    res(16'h1234, 16'h0000, 1'b1, 1'b0);
    st(8'h68);
    res(16'h1235, 16'h0000, 1'b1, 1'b0);
    st(8'h60);
    res(16'h0577, 16'h0000, 1'b1, 1'b0);
    st(8'h64);
    res(16'h0578, 16'h0000, 1'b1, 1'b0);
    st(8'h64);
    func = 6'h00;
    repeat (3) @(negedge ref_clk);
    st(8'h6C);
    func = ILAS_FUNC_L_LATCH;
    wr(ILAS_ADDR_INT_FUNC, ILAS_CLEAR_VALUE);
    st(8'h6C);
    func = ILAS_FUNC_R_LATCH;
    res(16'h0000, 16'h2001, 1'b0, 1'b1);
    st(8'h0C);
    rd(ILAS_ADDR_STATUS, 8'h0C);
    st(8'h4C);
    res(16'h0000, 16'h0FFF, 1'b0, 1'b1);
    st(8'h5C);
    wr(ILAS_ADDR_INT_FUNC, ILAS_CLEAR_VALUE);
    st(8'h7C);
    wr(ILAS_ADDR_UP_LOW, 8'h00);
    wr(ILAS_ADDR_UP_HIGH, 8'h20);
    check(up_lim, 16'h2000);
    func = ILAS_FUNC_L_LATCH;
    res(16'h1235, 16'h0000, 1'b1, 1'b0);
    st(8'h3C);
    osc_lost = 1'b1;
    repeat (8) @(negedge ref_clk);
    st(8'hBC);
    osc_lost = 1'b0;
    repeat (4) @(negedge ref_clk);
    st(8'h3C);
    // second reset in mid-run: limits return to zero, settle runs again
    reset = 1'b1;
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    check(up_lim, 16'h0000);
    check(lo_lim, 16'h0000);
    @(negedge ref_clk);
    check({15'h0000, settle_busy}, 16'h0001);
    repeat (30) @(negedge ref_clk);
    st(8'h68);
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    stop_test();
  end
endmodule : ilas_limits_status_test
